// [rtl/cfg_port_ctl.sv]
// controller end: reset sequencing and serial cycles
`timescale 1ns/100ps
`include "cfg_port_regs.svh"

module cfg_port_ctl #(
  parameter int PWR_WAIT = `PWR_WAIT_CYC,
  parameter int HALF     = `SCLK_HALF_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       PARALLEL_MODE_I,
  input  wire logic       START_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  output logic            READY_O,
  output logic            DONE_O,
  output logic [7:0]      RDATA_O,
  cfg_link_if.ctl         LINK
);

  localparam logic [17:0] PWR_LD  = 18'(PWR_WAIT - 1);
  localparam logic [17:0] HALF_LD = 18'(HALF - 1);
  // shortest legal pulse; the 1 us ceiling is far away
  localparam logic [17:0] RST_LD  = 18'(`RST_MIN_CYC - 1);
  localparam logic [17:0] GAP_LD  = 18'(`RST_GAP_CYC - 1);

  cfg_port_pkg::ctl_state_type state_r;
  logic [17:0]             tmr_r;
  logic [3:0]              bits_r;
  logic [`WORD_BITS-1:0]   sh_r;
  logic [`DATA_BITS-1:0]   rx_r;
  logic [1:0]              sdo_r;
  logic                    sclk_r;
  logic                    sel_n_r;
  logic                    sdi_r;
  logic                    rst_r;
  logic                    expired;

  assign expired = (tmr_r == 18'h00000);

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sdo_r <= 2'h0;
    end
    else
    begin
      sdo_r <= {sdo_r[0], LINK.serial_out_line};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_r <= cfg_port_pkg::S_PWR;
      tmr_r   <= PWR_LD;
      bits_r  <= 4'h0;
      sh_r    <= 16'h0000;
      rx_r    <= 8'h00;
      sclk_r  <= 1'b0;
      sel_n_r <= 1'b1;
      sdi_r   <= 1'b0;
      rst_r   <= 1'b0;
      READY_O <= 1'b0;
      DONE_O  <= 1'b0;
      RDATA_O <= 8'h00;
    end
    else if (PARALLEL_MODE_I)
    begin
      state_r <= cfg_port_pkg::S_PWR;
      tmr_r   <= PWR_LD;
      rst_r   <= 1'b1;
      sclk_r  <= 1'b0;
      sel_n_r <= 1'b1;
      READY_O <= 1'b0;
      DONE_O  <= 1'b0;
    end
    else
    begin
      DONE_O <= 1'b0;
      if (!expired)
      begin
        tmr_r <= tmr_r - 18'h00001;
      end
      unique case (state_r)
        cfg_port_pkg::S_PWR:
        begin
          rst_r <= 1'b0;
          if (expired)
          begin
            rst_r   <= 1'b1;
            tmr_r   <= RST_LD;
            state_r <= cfg_port_pkg::S_RST;
          end
        end
        cfg_port_pkg::S_RST:
        begin
          if (expired)
          begin
            rst_r   <= 1'b0;
            tmr_r   <= GAP_LD;
            state_r <= cfg_port_pkg::S_GAP;
          end
        end
        cfg_port_pkg::S_GAP:
        begin
          if (expired)
          begin
            READY_O <= 1'b1;
            state_r <= cfg_port_pkg::S_IDLE;
          end
        end
        cfg_port_pkg::S_IDLE:
        begin
          if (START_I)
          begin
            // address field names the register to return
            sh_r    <= {ADDR_I, WDATA_I};
            sdi_r   <= ADDR_I[7];
            sel_n_r <= 1'b0;
            bits_r  <= 4'h0;
            tmr_r   <= HALF_LD;
            READY_O <= 1'b0;
            state_r <= cfg_port_pkg::S_SETUP;
          end
        end
        cfg_port_pkg::S_SETUP:
        begin
          if (expired)
          begin
            sclk_r  <= 1'b1;
            tmr_r   <= HALF_LD;
            state_r <= cfg_port_pkg::S_SHIFT;
          end
        end
        cfg_port_pkg::S_SHIFT:
        begin
          if (expired)
          begin
            tmr_r  <= HALF_LD;
            sclk_r <= ~sclk_r;
            if (sclk_r)
            begin
              if (bits_r >= 4'h8)
              begin
                rx_r <= {rx_r[6:0], sdo_r[1]};
              end
              sdi_r  <= sh_r[14];
              sh_r   <= {sh_r[14:0], 1'b0};
              bits_r <= bits_r + 4'h1;
              if (bits_r == 4'hF)
              begin
                state_r <= cfg_port_pkg::S_HOLD;
              end
            end
          end
        end
        cfg_port_pkg::S_HOLD:
        begin
          if (expired)
          begin
            sel_n_r <= 1'b1;
            tmr_r   <= HALF_LD;
            state_r <= cfg_port_pkg::S_END;
          end
        end
        cfg_port_pkg::S_END:
        begin
          if (expired)
          begin
            DONE_O  <= 1'b1;
            READY_O <= 1'b1;
            RDATA_O <= rx_r;
            state_r <= cfg_port_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  assign LINK.sclk            = sclk_r;
  assign LINK.serial_select_n = sel_n_r;
  assign LINK.serial_in_line  = sdi_r;
  assign LINK.hw_reset        = rst_r;

endmodule : cfg_port_ctl

// [rtl/cfg_port_regs.svh]
// offsets, field positions, reset values and timing counts of the port
`ifndef CFG_PORT_REGS_SVH
`define CFG_PORT_REGS_SVH

`define CLK_PERIOD_NS     4
`define WORD_BITS         16
`define ADDR_BITS         8
`define DATA_BITS         8
`define REG_COUNT         8

`define REG_READOUT_ADDR  8'h00
`define REG_SPEED_ADDR    8'h01
`define REG_OUTMODE_ADDR  8'h02
`define READOUT_BIT       0
`define LOW_SPEED_BIT     0
`define CMOS_MODE_BIT     0
`define REG_RST_VAL       8'h00

`define SCLK_HALF_NS      25
`define SCLK_HALF_CYC     ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_WAIT_NS       1000000
`define PWR_WAIT_CYC      ((`PWR_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_MIN_NS        10
`define RST_MIN_CYC       ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_MAX_NS        1000
`define RST_MAX_CYC       (`RST_MAX_NS / `CLK_PERIOD_NS)
`define RST_GAP_NS        100
`define RST_GAP_CYC       ((`RST_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/cfg_port_pkg.sv]
// types of the serial configuration port: controller state codes and the byte type used by the converter end
package cfg_port_pkg;

  typedef logic [7:0] byte_type;

  typedef enum logic [2:0] {
    S_PWR   = 3'h0,
    S_RST   = 3'h1,
    S_GAP   = 3'h2,
    S_IDLE  = 3'h3,
    S_SETUP = 3'h4,
    S_SHIFT = 3'h5,
    S_HOLD  = 3'h6,
    S_END   = 3'h7
  } ctl_state_type;

endpackage : cfg_port_pkg

// [rtl/cfg_link_if.sv]
// serial link wires between the controller and the converter port
`timescale 1ns/100ps

interface cfg_link_if;
  logic sclk;
  logic serial_select_n;
  logic serial_in_line;
  logic serial_out_line;
  logic hw_reset;

  modport dev (
    input  sclk,
    input  serial_select_n,
    input  serial_in_line,
    input  hw_reset,
    output serial_out_line
  );

  modport ctl (
    output sclk,
    output serial_select_n,
    output serial_in_line,
    output hw_reset,
    input  serial_out_line
  );
endinterface : cfg_link_if

// [rtl/cfg_port_dev.sv]
// converter end: serial register port with readback
`timescale 1ns/100ps
`include "cfg_port_regs.svh"
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - low-speed mode is set only over serial port
// - readback bit set blocks later register writes
// - read cycle carries register address in A[7:0]
// - readback shifts D[7:0] out on serial out
// - controller samples readback bits at sclk fall
// - clearing readback bit re-enables register writes
// - readback same for double-rate and parallel output
// - serial out driven low while readback off
// - register 00h never returns its contents
// - serial clock kept at or below 20 MHz
// - wait 1 ms after supplies before reset
// - reset pulse between 10 ns and 1 us
// - 100 ns from reset release to select
// - serial mode init by one high reset pulse
// - parallel configuration holds reset pin high
// - word latched on sixteenth sclk fall, select low
////////////////////////////////////////////////////////////////////////

module cfg_port_dev #(
  parameter int NREG = `REG_COUNT
) (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  cfg_link_if.dev   LINK,
  output logic      LOW_SPEED_O,
  output logic      CMOS_MODE_O,
  output logic      READOUT_O
);

  ////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection

  logic [3:0]               meta_r;
  logic [3:0]               sync_r;
  logic                     sclk_d_r;
  logic                     sclk_s;
  logic                     sel_n_s;
  logic                     din_s;
  logic                     hw_rst_s;
  logic                     rise;
  logic                     fall;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      // idle levels: sclk low, select high, so no false edge follows reset
      meta_r   <= 4'h2;
      sync_r   <= 4'h2;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      meta_r   <= {LINK.hw_reset, LINK.serial_in_line,
                   LINK.serial_select_n, LINK.sclk};
      sync_r   <= meta_r;
      sclk_d_r <= sync_r[0];
    end
  end

  assign sclk_s   = sync_r[0];
  assign sel_n_s  = sync_r[1];
  assign din_s    = sync_r[2];
  assign hw_rst_s = sync_r[3];
  assign rise     = sclk_s & ~sclk_d_r;
  assign fall     = ~sclk_s & sclk_d_r;

  ////////////////////////////////////////////////////////////////////
  // register file helpers

  cfg_port_pkg::byte_type   regs_r [NREG];
  logic [4:0]               cnt_r;
  logic [`WORD_BITS-1:0]    in_sh_r;
  logic [`DATA_BITS-1:0]    rd_sh_r;
  logic                     out_r;
  logic                     readout;
  logic                     latch;
  logic                     wr_en;
  cfg_port_pkg::byte_type   rd_val;

  function automatic logic addr_ok(input cfg_port_pkg::byte_type a);
    addr_ok = (32'(a) < NREG);
  endfunction : addr_ok

  function automatic logic [2:0] idx(input cfg_port_pkg::byte_type a);
    idx = a[2:0];
  endfunction : idx

  // unmapped addresses and 00h read as zero
  function automatic cfg_port_pkg::byte_type rd_fn(
    input cfg_port_pkg::byte_type a
  );
    rd_fn = 8'h00;
    if (addr_ok(a) && (a != `REG_READOUT_ADDR))
    begin
      rd_fn = regs_r[idx(a)];
    end
  endfunction : rd_fn

  assign readout = regs_r[0][`READOUT_BIT];
  assign latch   = fall & ~sel_n_s & (cnt_r == 5'h10);
  // 00h stays writable so the readback bit can be cleared again
  assign wr_en   = latch & addr_ok(in_sh_r[15:8])
                 & (~readout
                    | (in_sh_r[15:8] == `REG_READOUT_ADDR));

  // process form so a register update also refreshes the value
  always_comb
  begin
    rd_val = rd_fn(in_sh_r[7:0]);
  end

  ////////////////////////////////////////////////////////////////////
  // bit counter and input shifter

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cnt_r <= 5'h00;
    end
    else if (hw_rst_s || sel_n_s)
    begin
      cnt_r <= 5'h00;
    end
    else if (rise && (cnt_r < 5'h10))
    begin
      cnt_r <= cnt_r + 5'h01;
    end
    else if (latch)
    begin
      // parks past sixteen so extra edges latch nothing
      cnt_r <= 5'h11;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      in_sh_r <= 16'h0000;
    end
    else if (rise && !sel_n_s && (cnt_r < 5'h10))
    begin
      in_sh_r <= {in_sh_r[14:0], din_s};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs_r[i] <= `REG_RST_VAL;
      end
    end
    else if (hw_rst_s)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs_r[i] <= `REG_RST_VAL;
      end
    end
    else if (wr_en)
    begin
      regs_r[idx(in_sh_r[15:8])] <= in_sh_r[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // readback shifter
  // bits change on falling edges so a whole sclk period separates a
  // change from the controller's next sampling fall

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      out_r   <= 1'b0;
      rd_sh_r <= 8'h00;
    end
    else if (hw_rst_s || sel_n_s || !readout)
    begin
      out_r   <= 1'b0;
      rd_sh_r <= 8'h00;
    end
    else if (fall && (cnt_r == 5'h08))
    begin
      // output format bit plays no part here
      out_r   <= rd_val[7];
      rd_sh_r <= {rd_val[6:0], 1'b0};
    end
    else if (fall && (cnt_r > 5'h08) && (cnt_r < 5'h10))
    begin
      out_r   <= rd_sh_r[7];
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
    end
    else if (fall)
    begin
      out_r <= 1'b0;
    end
  end

  assign LINK.serial_out_line = out_r;

  ////////////////////////////////////////////////////////////////////
  // user-side mode outputs

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      LOW_SPEED_O <= 1'b0;
      CMOS_MODE_O <= 1'b0;
      READOUT_O   <= 1'b0;
    end
    else
    begin
      LOW_SPEED_O <= regs_r[1][`LOW_SPEED_BIT];
      CMOS_MODE_O <= regs_r[2][`CMOS_MODE_BIT];
      READOUT_O   <= readout;
    end
  end

endmodule : cfg_port_dev

// [dv/cfg_link_monitor.sv]
// concurrent checks on the serial configuration link
`timescale 1ns/100ps
`include "cfg_port_regs.svh"
////////////////////////////////////////////////////////////////////////
module cfg_link_monitor (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  input  wire logic sclk_i,
  input  wire logic serial_select_n_i,
  input  wire logic serial_in_line_i,
  input  wire logic serial_out_line_i,
  input  wire logic hw_reset_i
);
  localparam int GAP = `RST_GAP_CYC;
  logic [4:0] rise_cnt_r;
  logic [4:0] fall_cnt_r;
  logic [7:0] gap_cnt_r;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
////////////////////////////////////////////////////////////////////////
  // edges counted per frame, cleared while select is high
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rise_cnt_r <= 5'h00;
    end
    else if (serial_select_n_i)
    begin
      rise_cnt_r <= 5'h00;
    end
    else if ($rose(sclk_i))
    begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fall_cnt_r <= 5'h00;
    end
    else if (serial_select_n_i)
    begin
      fall_cnt_r <= 5'h00;
    end
    else if ($fell(sclk_i))
    begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end

  // saturates so a long idle never wraps into a short gap
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      gap_cnt_r <= 8'h00;
    end
    else if (hw_reset_i)
    begin
      gap_cnt_r <= 8'h00;
    end
    else if (gap_cnt_r != 8'hFF)
    begin
      gap_cnt_r <= gap_cnt_r + 8'h01;
    end
  end
////////////////////////////////////////////////////////////////////////
  chk_sclk_high_min: assert property
    ($rose(sclk_i) |-> sclk_i [*7]) else $error("sclk high phase short");
  chk_sclk_low_min: assert property
    ($fell(sclk_i) |-> !sclk_i [*7]) else $error("sclk low phase short");
  chk_select_setup: assert property
    ($rose(sclk_i) |-> !serial_select_n_i
      && !$past(serial_select_n_i, 6))
    else $error("sclk rose without select setup");
  chk_sdi_hold_high: assert property
    (sclk_i && $past(sclk_i) |-> $stable(serial_in_line_i)
      && $stable(serial_select_n_i))
    else $error("input data moved while sclk high");
  chk_frame_bits: assert property
    ($rose(serial_select_n_i) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  chk_frame_gap: assert property
    ($rose(serial_select_n_i) |-> serial_select_n_i [*7])
    else $error("select high gap too short");
  chk_out_at_fall: assert property
    ($changed(serial_out_line_i) |-> !sclk_i)
    else $error("readback bit moved while sclk high");
  chk_out_window: assert property
    (serial_out_line_i |-> !serial_select_n_i && fall_cnt_r >= 5'h08)
    else $error("serial out high outside data phase");
  chk_hwrst_width: assert property
    ($rose(hw_reset_i) |-> hw_reset_i [*3])
    else $error("reset pulse short");
  chk_reset_gap: assert property
    ($fell(serial_select_n_i) |-> gap_cnt_r >= GAP)
    else $error("select fell too soon after reset");

  cov_frame: cover property ($rose(serial_select_n_i));
  cov_readback: cover property ($rose(serial_out_line_i));
  cov_hwrst: cover property ($rose(hw_reset_i));
endmodule : cfg_link_monitor

// [dv/tb_top.sv]
// self-checking bench: controller and converter ends face to face
`timescale 1ns/100ps
`include "cfg_port_regs.svh"
////////////////////////////////////////////////////////////////////////
module tb_top;
  // short power-up wait so the run stays brief
  localparam int         PWR_SIM  = 20;
  logic                  clk      = 1'b0;
  logic                  rst_n    = 1'b0;
  logic                  par_mode = 1'b0;
  logic                  start    = 1'b0;
  cfg_port_pkg::byte_type addr    = 8'h00;
  cfg_port_pkg::byte_type wdata   = 8'h00;
  cfg_port_pkg::byte_type rdata;
  cfg_port_pkg::byte_type exp_q [4] = '{8'h01, 8'h01, 8'hA5, 8'h00};
  cfg_port_pkg::byte_type adr_q [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  logic                  ready;
  logic                  done;
  logic                  low_speed;
  logic                  cmos_mode;
  logic                  readout;
  int                    error_cnt = 0;
  int                    checked   = 0;

  cfg_link_if cfg_link_if_inst ();

  cfg_port_ctl #(.PWR_WAIT(PWR_SIM), .HALF(7)) cfg_port_ctl_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .PARALLEL_MODE_I(par_mode),
    .START_I(start), .ADDR_I(addr), .WDATA_I(wdata), .READY_O(ready),
    .DONE_O(done), .RDATA_O(rdata), .LINK(cfg_link_if_inst.ctl));

  cfg_port_dev #(.NREG(8)) cfg_port_dev_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .LINK(cfg_link_if_inst.dev),
    .LOW_SPEED_O(low_speed), .CMOS_MODE_O(cmos_mode),
    .READOUT_O(readout));

  cfg_link_monitor cfg_link_monitor_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .sclk_i(cfg_link_if_inst.sclk),
    .serial_select_n_i(cfg_link_if_inst.serial_select_n),
    .serial_in_line_i(cfg_link_if_inst.serial_in_line),
    .serial_out_line_i(cfg_link_if_inst.serial_out_line),
    .hw_reset_i(cfg_link_if_inst.hw_reset));

  initial
  begin
    forever #2 clk = ~clk;
  end
////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic cmp_bit(input string n, input logic e, input logic s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input string n, input cfg_port_pkg::byte_type e,
                          input cfg_port_pkg::byte_type s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_byte

  // levels a wait can watch: ready, done, reset pin high, reset pin low
  function automatic logic watched(input logic [1:0] s);
    case (s)
      2'h0:    watched = ready;
      2'h1:    watched = done;
      2'h2:    watched = cfg_link_if_inst.hw_reset;
      default: watched = ~cfg_link_if_inst.hw_reset;
    endcase
  endfunction : watched

  // bounded wait for one level; k gives the cycles spent
  task automatic wait_for(input string n, input logic [1:0] s,
                          input int lim, output int k);
    k = 0;
    while (watched(s) !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= lim)
    begin
      error_cnt++;
      $display("MISMATCH %s expected 1 seen timeout", n);
      results();
    end
  endtask : wait_for

  task automatic do_reset();
    int   k;
    logic w_ok;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_for("hw_reset high", 2'h2, 1000, k);
    cmp_byte("power wait", 8'(PWR_SIM), 8'(k));
    wait_for("hw_reset low", 2'h3, 1000, k);
    w_ok = (k >= `RST_MIN_CYC) && (k <= `RST_MAX_CYC);
    cmp_bit("reset width", 1'b1, w_ok);
    wait_for("ready", 2'h0, 1000, k);
  endtask : do_reset

  // one serial cycle: address then data byte, readback in rdata
  task automatic xfer(input cfg_port_pkg::byte_type a,
                      input cfg_port_pkg::byte_type d);
    int k;
    wait_for("ready", 2'h0, 1000, k);
    @(posedge clk);
    start <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    start <= 1'b0;
    #1;
    wait_for("done", 2'h1, 400, k);
  endtask : xfer
////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    cmp_bit("serial_out_line", 1'b0, cfg_link_if_inst.serial_out_line);
    $display("test reset sequence done");
    xfer(8'h01, 8'h01);
    cmp_bit("low_speed", 1'b1, low_speed);
    cmp_byte("rdata readback off", 8'h00, rdata);
    xfer(8'h02, 8'h01);
    cmp_bit("cmos_mode", 1'b1, cmos_mode);
    xfer(8'h03, 8'hA5);
    $display("test register writes done");
    xfer(8'h00, 8'h01);
    cmp_bit("readout", 1'b1, readout);
    xfer(8'h01, 8'h00);
    cmp_bit("low_speed blocked", 1'b1, low_speed);
    // write data 01h keeps readback on when register 00h is named
    for (int i = 0; i < 4; i++)
    begin
      xfer(adr_q[i], 8'h01);
      cmp_byte("rdata", exp_q[i], rdata);
    end
    xfer(8'h00, 8'h00);
    cmp_bit("readout cleared", 1'b0, readout);
    xfer(8'h02, 8'h00);
    cmp_bit("cmos_mode off", 1'b0, cmos_mode);
    xfer(8'h00, 8'h01);
    xfer(8'h03, 8'h01);
    cmp_byte("rdata other mode", 8'hA5, rdata);
    xfer(8'h00, 8'h00);
    $display("test readback done");
    @(posedge clk);
    par_mode <= 1'b1;
    repeat (40) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (300) @(posedge clk);
    #1;
    cmp_bit("hw_reset", 1'b1, cfg_link_if_inst.hw_reset);
    cmp_bit("select_n", 1'b1, cfg_link_if_inst.serial_select_n);
    cmp_bit("low_speed cleared", 1'b0, low_speed);
    @(posedge clk);
    par_mode <= 1'b0;
    do_reset();
    xfer(8'h02, 8'h01);
    cmp_bit("cmos_mode again", 1'b1, cmos_mode);
    $display("test parallel and second reset done");
    results();
  end
endmodule : tb_top
